// ===== logic/timecode_gen_mtc_window_burn.sv
// Contract
// - Start time loadable; zero command clears it
// - Run advances address once per frame
// - Stop holds current address
// - MTC sent whenever LTC is output
// - LTC idle: full frame every 200 ms
// - Idle setting off mutes idle bursts
// - Overlay shows selected positional reference
// - No overlay without incoming video (code also enables it when only reference video is present)
// - Overlay enable superimposes, else pass through
// - Overlay size small or large
// - Vertical position 10% to 50% steps
// - Five horizontal positions
// - Four colour choices, video ones boxless
// - Default colour white on black
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns

// ============================================================
// Byte FIFO for the MTC stream
// ============================================================
module mtc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("mtc_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;

  assign in_ready  = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge hclk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_ff <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ptr_ff <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

endmodule : mtc_fifo

// ============================================================
// Time code generator, MTC sender, overlay control
// ============================================================
module timecode_gen_mtc_window_burn
  import tc_pkg::*;
#(
  parameter int BURST_CYCLES = BURST_CYC,
  parameter int FIFO_DEPTH   = 32
) (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // References
  input  wire logic        frame_tick,
  input  wire logic        pos_ref_generate,
  input  wire tc_s         ext_tc,
  input  wire logic        ltc_out_active,
  input  wire logic        video_in_present,
  input  wire logic        video_ref_present,
  // MTC byte stream
  output logic             mtc_valid,
  input  wire logic        mtc_ready,
  output logic [7:0]       mtc_data,
  // Character generator and code insertion
  output logic             overlay_active,
  output tc_s              overlay_tc,
  output ovl_cfg_s         overlay_cfg,
  output logic             vertical_code_insert,
  output logic [3:0]       insert_line_pair
);

  initial begin
    if (BURST_CYCLES < 2 || FIFO_DEPTH < 16)
      $error("timecode_gen: BURST_CYCLES >= 2, FIFO_DEPTH >= 16");
  end

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_QF, SEQ_FULL} seq_e;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [4:0] frame_last(input rate_e r);
    case (r)
      RATE_24: frame_last = 5'h17;
      RATE_25: frame_last = 5'h18;
      default: frame_last = 5'h1D;
    endcase
  endfunction : frame_last

  function automatic logic [31:0] tc_word(input tc_s t);
    tc_word = '0;
    tc_word[TC_FRM +: 5] = t.frames;
    tc_word[TC_SEC +: 6] = t.seconds;
    tc_word[TC_MIN +: 6] = t.minutes;
    tc_word[TC_HRS +: 5] = t.hours;
  endfunction : tc_word

  // ==========================================================
  // Bus and registers
  // ==========================================================
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        ctl_run_ff;
  logic        ctl_idle_ff;
  logic        ctl_ovl_ff;
  logic        ctl_vic_ff;
  rate_e       ctl_rate_ff;
  logic [3:0]  ctl_line_ff;
  tc_s         start_ff;
  ovl_cfg_s    ovl_ff;
  tc_s         gen_ff;
  tc_s         pos_tc;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        video_any;
  logic        addr_ok;
  logic        do_zero;
  logic        do_load;
  logic [31:0] rd_mux;

  assign addr_ok   = hsel && hready && htrans[1];
  assign video_any = video_in_present || video_ref_present;
  assign pos_tc    = pos_ref_generate ? gen_ff : ext_tc;
  assign do_zero   = wr_pend_ff && wr_addr_ff == OFS_CTRL
                     && hwdata[CTL_ZERO];
  assign do_load   = wr_pend_ff && wr_addr_ff == OFS_CTRL
                     && hwdata[CTL_LOAD];

  always_comb begin
    rd_mux = '0;
    case (haddr)
      OFS_CTRL: begin
        rd_mux[CTL_RUN]        = ctl_run_ff;
        rd_mux[CTL_IDLE]       = ctl_idle_ff;
        rd_mux[CTL_OVL]        = ctl_ovl_ff;
        rd_mux[CTL_VIC]        = ctl_vic_ff;
        rd_mux[CTL_RATE +: 2]  = ctl_rate_ff;
        rd_mux[CTL_LINE +: 4]  = ctl_line_ff;
      end
      OFS_START: rd_mux = tc_word(start_ff);
      OFS_OVL: begin
        rd_mux[OVL_SIZE]      = ovl_ff.size;
        rd_mux[OVL_VPOS +: 3] = ovl_ff.vpos;
        rd_mux[OVL_HPOS +: 3] = ovl_ff.hpos;
        rd_mux[OVL_COL +: 2]  = ovl_ff.colour;
      end
      OFS_GEN: rd_mux = tc_word(gen_ff);
      OFS_POS: rd_mux = tc_word(pos_tc);
      OFS_STAT: begin
        rd_mux[ST_RUN]   = ctl_run_ff;
        rd_mux[ST_LTC]   = ltc_out_active;
        rd_mux[ST_VID]   = video_any;
        rd_mux[ST_EMPTY] = !fifo_out_valid;
        rd_mux[ST_FULL]  = !fifo_in_ready;
      end
      default: rd_mux = '0;
    endcase
  end

  // Zero-wait slave: reads answer in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= '0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pend_ff <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_ff <= haddr;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_run_ff  <= 1'b0;
      ctl_idle_ff <= 1'b0;
      ctl_ovl_ff  <= 1'b0;
      ctl_vic_ff  <= 1'b0;
      ctl_rate_ff <= RATE_30;
      ctl_line_ff <= LINE_RST;
    end else if (wr_pend_ff && wr_addr_ff == OFS_CTRL) begin
      ctl_run_ff  <= hwdata[CTL_RUN];
      ctl_idle_ff <= hwdata[CTL_IDLE];
      ctl_ovl_ff  <= hwdata[CTL_OVL];
      ctl_vic_ff  <= hwdata[CTL_VIC];
      ctl_rate_ff <= (hwdata[CTL_RATE +: 2] == 2'h3) ? RATE_30
                     : rate_e'(hwdata[CTL_RATE +: 2]);
      ctl_line_ff <= hwdata[CTL_LINE +: 4];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_ff <= TC_ZERO;
    end else if (do_zero) begin
      start_ff <= TC_ZERO;
    end else if (wr_pend_ff && wr_addr_ff == OFS_START) begin
      start_ff.frames  <= hwdata[TC_FRM +: 5];
      start_ff.seconds <= hwdata[TC_SEC +: 6];
      start_ff.minutes <= hwdata[TC_MIN +: 6];
      start_ff.hours   <= hwdata[TC_HRS +: 5];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovl_ff.size   <= SIZE_SMALL;
      ovl_ff.vpos   <= '0;
      ovl_ff.hpos   <= '0;
      ovl_ff.colour <= COL_WHITE_ON_BLACK;
    end else if (wr_pend_ff && wr_addr_ff == OFS_OVL) begin
      ovl_ff.size   <= size_e'(hwdata[OVL_SIZE]);
      ovl_ff.vpos   <= (hwdata[OVL_VPOS +: 3] > POS_MAX) ? POS_MAX
                       : hwdata[OVL_VPOS +: 3];
      ovl_ff.hpos   <= (hwdata[OVL_HPOS +: 3] > POS_MAX) ? POS_MAX
                       : hwdata[OVL_HPOS +: 3];
      ovl_ff.colour <= colour_e'(hwdata[OVL_COL +: 2]);
    end
  end

  // ==========================================================
  // Generator counter
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gen_ff <= TC_ZERO;
    end else if (do_zero) begin
      gen_ff <= TC_ZERO;
    end else if (do_load) begin
      gen_ff <= start_ff;
    end else if (ctl_run_ff && frame_tick) begin
      if (gen_ff.frames < frame_last(ctl_rate_ff)) begin
        gen_ff.frames <= gen_ff.frames + 1'b1;
      end else begin
        gen_ff.frames <= '0;
        if (gen_ff.seconds < MS_LAST) begin
          gen_ff.seconds <= gen_ff.seconds + 1'b1;
        end else begin
          gen_ff.seconds <= '0;
          if (gen_ff.minutes < MS_LAST) begin
            gen_ff.minutes <= gen_ff.minutes + 1'b1;
          end else begin
            gen_ff.minutes <= '0;
            gen_ff.hours   <= (gen_ff.hours >= HRS_LAST) ? 5'h00
                              : gen_ff.hours + 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // MTC message scheduling
  // ==========================================================
  logic [31:0] burst_cnt_ff;
  logic        qf_pend_ff;
  logic        full_pend_ff;
  logic        burst_due;
  seq_e        seq_ff;
  logic [3:0]  idx_ff;
  logic        half_ff;
  tc_s         snap_ff;
  logic [7:0]  seq_byte;
  logic        seq_push;
  logic        start_qf;
  logic        start_full;
  logic [2:0]  piece;
  logic [3:0]  nib;

  assign burst_due  = !ltc_out_active
                      && burst_cnt_ff == 32'(BURST_CYCLES - 1);
  assign start_qf   = seq_ff == SEQ_IDLE && qf_pend_ff;
  assign start_full = seq_ff == SEQ_IDLE && !qf_pend_ff
                      && full_pend_ff;
  assign seq_push   = seq_ff != SEQ_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_cnt_ff <= '0;
    end else if (ltc_out_active || burst_due) begin
      burst_cnt_ff <= '0;
    end else begin
      burst_cnt_ff <= burst_cnt_ff + 1'b1;
    end
  end

  // A new trigger in the cycle its pending flag is taken wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qf_pend_ff <= 1'b0;
    end else begin
      qf_pend_ff <= (qf_pend_ff && !start_qf)
                    || (frame_tick && ltc_out_active);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      full_pend_ff <= 1'b0;
    end else begin
      full_pend_ff <= (full_pend_ff && !start_full && !ltc_out_active)
                      || (burst_due && ctl_idle_ff);
    end
  end

  always_comb begin
    piece = {half_ff, idx_ff[2:1]};
    case (piece)
      3'h0:    nib = snap_ff.frames[3:0];
      3'h1:    nib = {3'h0, snap_ff.frames[4]};
      3'h2:    nib = snap_ff.seconds[3:0];
      3'h3:    nib = {2'h0, snap_ff.seconds[5:4]};
      3'h4:    nib = snap_ff.minutes[3:0];
      3'h5:    nib = {2'h0, snap_ff.minutes[5:4]};
      3'h6:    nib = snap_ff.hours[3:0];
      default: nib = {1'b0, ctl_rate_ff, snap_ff.hours[4]};
    endcase
    seq_byte = MTC_EOX;
    if (seq_ff == SEQ_QF) begin
      seq_byte = idx_ff[0] ? {1'b0, piece, nib} : MTC_QF;
    end else begin
      case (idx_ff)
        4'h0:    seq_byte = MTC_SOX;
        4'h1:    seq_byte = MTC_ALL;
        4'h2:    seq_byte = MTC_ALL;
        4'h3:    seq_byte = MTC_ID;
        4'h4:    seq_byte = MTC_ID;
        4'h5:    seq_byte = {1'b0, ctl_rate_ff, snap_ff.hours};
        4'h6:    seq_byte = {2'h0, snap_ff.minutes};
        4'h7:    seq_byte = {2'h0, snap_ff.seconds};
        4'h8:    seq_byte = {3'h0, snap_ff.frames};
        default: seq_byte = MTC_EOX;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_ff  <= SEQ_IDLE;
      idx_ff  <= '0;
      half_ff <= 1'b0;
      snap_ff <= TC_ZERO;
    end else begin
      case (seq_ff)
        SEQ_IDLE: begin
          idx_ff  <= '0;
          snap_ff <= pos_tc;
          if (start_qf) begin
            seq_ff <= SEQ_QF;
          end else if (start_full) begin
            seq_ff <= SEQ_FULL;
          end
        end
        SEQ_QF, SEQ_FULL: begin
          if (fifo_in_ready) begin
            idx_ff <= idx_ff + 1'b1;
            if (idx_ff == ((seq_ff == SEQ_QF) ? QF_BYTES : FF_BYTES)
                          - 4'h1) begin
              seq_ff <= SEQ_IDLE;
              if (seq_ff == SEQ_QF) begin
                half_ff <= !half_ff;
              end
            end
          end
        end
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // FIFO and output stage
  // ==========================================================
  logic [7:0] fifo_out_data;
  logic       take;

  assign take = fifo_out_valid && (!mtc_valid || mtc_ready);

  mtc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (seq_push),
    .in_ready  (fifo_in_ready),
    .in_data   (seq_byte),
    .out_valid (fifo_out_valid),
    .out_ready (take),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mtc_valid <= 1'b0;
      mtc_data  <= '0;
    end else if (take) begin
      mtc_valid <= 1'b1;
      mtc_data  <= fifo_out_data;
    end else if (mtc_ready) begin
      mtc_valid <= 1'b0;
    end
  end

  // ==========================================================
  // Character generator and insertion control
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overlay_active       <= 1'b0;
      overlay_tc           <= TC_ZERO;
      overlay_cfg          <= '0;
      vertical_code_insert <= 1'b0;
      insert_line_pair     <= LINE_RST;
    end else begin
      overlay_active       <= ctl_ovl_ff && video_any;
      overlay_tc           <= pos_tc;
      overlay_cfg          <= ovl_ff;
      vertical_code_insert <= ctl_vic_ff && video_any;
      insert_line_pair     <= ctl_line_ff;
    end
  end

endmodule : timecode_gen_mtc_window_burn

// ===== shared/tc_pkg.sv
package tc_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_KHZ    = 10_000;
  localparam int BURST_MS   = 200;
  localparam int BURST_CYC  = BURST_MS * CLK_KHZ;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_OVL   = 8'h08;
  localparam logic [7:0] OFS_GEN   = 8'h0C;
  localparam logic [7:0] OFS_POS   = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // Control register fields
  localparam int CTL_RUN   = 0;
  localparam int CTL_ZERO  = 1;
  localparam int CTL_LOAD  = 2;
  localparam int CTL_IDLE  = 3;
  localparam int CTL_OVL   = 4;
  localparam int CTL_VIC   = 5;
  localparam int CTL_RATE  = 6;
  localparam int CTL_LINE  = 8;
  localparam logic [3:0] LINE_RST = 4'h0;

  // Overlay register fields
  localparam int OVL_SIZE = 0;
  localparam int OVL_VPOS = 4;
  localparam int OVL_HPOS = 8;
  localparam int OVL_COL  = 12;
  localparam logic [2:0] POS_MAX = 3'h4;

  // Time code word fields
  localparam int TC_FRM = 0;
  localparam int TC_SEC = 8;
  localparam int TC_MIN = 16;
  localparam int TC_HRS = 24;
  localparam logic [4:0] HRS_LAST = 5'h17;
  localparam logic [5:0] MS_LAST  = 6'h3B;

  // Status register fields
  localparam int ST_RUN   = 0;
  localparam int ST_LTC   = 1;
  localparam int ST_VID   = 2;
  localparam int ST_EMPTY = 3;
  localparam int ST_FULL  = 4;

  // ==========================================================
  // MIDI time code bytes
  // ==========================================================
  localparam logic [7:0] MTC_QF    = 8'hF1;
  localparam logic [7:0] MTC_SOX   = 8'hF0;
  localparam logic [7:0] MTC_ALL   = 8'h7F;
  localparam logic [7:0] MTC_ID    = 8'h01;
  localparam logic [7:0] MTC_EOX   = 8'hF7;
  localparam logic [3:0] QF_BYTES  = 4'h8;
  localparam logic [3:0] FF_BYTES  = 4'hA;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {RATE_24, RATE_25, RATE_30} rate_e;
  typedef enum logic {SIZE_SMALL, SIZE_LARGE} size_e;
  typedef enum logic [1:0] {
    COL_WHITE_ON_BLACK, COL_BLACK_ON_WHITE,
    COL_WHITE_ON_VIDEO, COL_BLACK_ON_VIDEO
  } colour_e;

  typedef struct packed {
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [4:0] frames;
  } tc_s;

  typedef struct packed {
    size_e      size;
    logic [2:0] vpos;
    logic [2:0] hpos;
    colour_e    colour;
  } ovl_cfg_s;

  localparam tc_s TC_ZERO = '0;

endpackage : tc_pkg

// ===== sim/mtc_sink.sv
`timescale 1ns/1ns

// ============================================================
// MIDI reader model: counts bytes, can stall
// ============================================================
module mtc_sink
  import tc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       mtc_valid,
  input  wire logic [7:0] mtc_data,
  input  wire logic       stall,
  output logic            mtc_ready,
  output int              n_bytes,
  output int              n_qf,
  output int              n_ff,
  output int              gap,
  output logic [7:0]      pre_ff
);
  int         cyc;
  int         t_ff;
  logic [7:0] last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc <= 0; t_ff <= 0; last <= 8'h00; mtc_ready <= 1'b0;
      n_bytes <= 0; n_qf <= 0; n_ff <= 0; gap <= 0; pre_ff <= 8'h00;
    end else begin
      cyc       <= cyc + 1;
      mtc_ready <= !stall;
      if (mtc_valid && mtc_ready) begin
        n_bytes <= n_bytes + 1;
        last    <= mtc_data;
        if (mtc_data == MTC_QF) n_qf <= n_qf + 1;
        if (mtc_data == MTC_SOX) begin
          n_ff   <= n_ff + 1;
          gap    <= cyc - t_ff;
          t_ff   <= cyc;
          pre_ff <= last;
        end
      end
    end
  end
endmodule : mtc_sink

// ===== sim/timecode_checker.sv
`timescale 1ns/1ns

// ============================================================
// Port checker for the time code block
// ============================================================
module tc_checker
  import tc_pkg::*;
(
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // References
  input wire logic        frame_tick,
  input wire logic        pos_ref_generate,
  input wire tc_s         ext_tc,
  input wire logic        ltc_out_active,
  input wire logic        video_in_present,
  input wire logic        video_ref_present,
  // Stream and overlay
  input wire logic        mtc_valid,
  input wire logic        mtc_ready,
  input wire logic [7:0]  mtc_data,
  input wire logic        overlay_active,
  input wire tc_s         overlay_tc,
  input wire ovl_cfg_s    overlay_cfg,
  input wire logic        vertical_code_insert
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // Assertions
  // ==========================================================
  bus_ready_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  bus_okay_a: assert property (!hresp)
    else $error("slave gave an error response");
  rdata_hold_a: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  mtc_hold_a: assert property (
    mtc_valid && !mtc_ready |=> mtc_valid && $stable(mtc_data))
    else $error("stream byte dropped before acceptance");
  qf_start_a: assert property (
    frame_tick && ltc_out_active && !mtc_valid
    |-> ##[1:16] (mtc_valid && mtc_data == MTC_QF))
    else $error("no quarter frame after frame tick");
  ovl_video_a: assert property (
    !video_in_present && !video_ref_present |=> !overlay_active)
    else $error("overlay active without video");
  vic_video_a: assert property (
    !video_in_present && !video_ref_present |=> !vertical_code_insert)
    else $error("code insertion active without video");
  tc_select_a: assert property (
    !pos_ref_generate |=> overlay_tc == $past(ext_tc))
    else $error("overlay time not from external reference");
  pos_clamp_a: assert property (
    overlay_cfg.vpos <= POS_MAX && overlay_cfg.hpos <= POS_MAX)
    else $error("overlay position out of range");

  // ==========================================================
  // Covers
  // ==========================================================
  c_qf:  cover property (mtc_valid && mtc_ready && mtc_data == MTC_QF);
  c_ff:  cover property (mtc_valid && mtc_ready && mtc_data == MTC_SOX);
  c_ovl: cover property (overlay_active);
  c_stl: cover property (mtc_valid && !mtc_ready);
endmodule : tc_checker

bind timecode_gen_mtc_window_burn tc_checker i_tc_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .frame_tick(frame_tick),
  .pos_ref_generate(pos_ref_generate), .ext_tc(ext_tc),
  .ltc_out_active(ltc_out_active),
  .video_in_present(video_in_present),
  .video_ref_present(video_ref_present), .mtc_valid(mtc_valid),
  .mtc_ready(mtc_ready), .mtc_data(mtc_data),
  .overlay_active(overlay_active), .overlay_tc(overlay_tc),
  .overlay_cfg(overlay_cfg),
  .vertical_code_insert(vertical_code_insert)
);

// ===== sim/timecode_gen_mtc_window_burn_tb.sv
`timescale 1ns/1ns

module timecode_gen_mtc_window_burn_tb
  import tc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr, mtc_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic frame_tick, pos_ref_generate, ltc_out_active, stall;
  logic video_in_present, video_ref_present, mtc_valid, mtc_ready;
  logic overlay_active, vertical_code_insert;
  logic [3:0] insert_line_pair;
  logic [7:0] pre_ff;
  tc_s ext_tc, overlay_tc;
  ovl_cfg_s overlay_cfg;
  int n_errors, checks, n_bytes, n_qf, n_ff, gap, k;

  assign hready = hreadyout;

  timecode_gen_mtc_window_burn #(.BURST_CYCLES(200), .FIFO_DEPTH(32))
    i_timecode_gen_mtc_window_burn (.*);
  mtc_sink i_mtc_sink (.*);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rd

  task automatic tick;
    frame_tick <= 1'b1;
    @(posedge hclk);
    frame_tick <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : tick

  function automatic logic [31:0] tcw(input int h, m, s, f);
    return {3'h0, 5'(h), 2'h0, 6'(m), 2'h0, 6'(s), 3'h0, 5'(f)};
  endfunction : tcw

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    final_report();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    logic [4:0] lasts [3];
    lasts = '{5'h17, 5'h18, 5'h1D};
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; frame_tick = 1'b0;
    pos_ref_generate = 1'b1; ext_tc = TC_ZERO; ltc_out_active = 1'b0;
    video_in_present = 1'b0; video_ref_present = 1'b0; stall = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_CTRL, 32'h80);
    rd(OFS_OVL, 32'h0);
    rd(8'h18, 32'h0);
    chk(32'(overlay_cfg.colour), 32'(COL_WHITE_ON_BLACK));
    $display("reset test done");
    wr(OFS_START, tcw(23, 59, 59, 29));
    wr(OFS_CTRL, 32'h84);
    rd(OFS_GEN, tcw(23, 59, 59, 29));
    wr(OFS_CTRL, 32'h81);
    tick();
    rd(OFS_GEN, 32'h0);
    tick();
    rd(OFS_GEN, tcw(0, 0, 0, 1));
    wr(OFS_CTRL, 32'h80);
    tick();
    tick();
    rd(OFS_GEN, tcw(0, 0, 0, 1));
    rd(OFS_POS, tcw(0, 0, 0, 1));
    for (int r = 0; r < 3; r++) begin
      wr(OFS_START, tcw(1, 2, 59, lasts[r]));
      wr(OFS_CTRL, (32'(r) << CTL_RATE) | 32'h4);
      wr(OFS_CTRL, (32'(r) << CTL_RATE) | 32'h1);
      tick();
      rd(OFS_GEN, tcw(1, 3, 0, 0));
    end
    wr(OFS_CTRL, 32'h82);
    rd(OFS_START, 32'h0);
    rd(OFS_GEN, 32'h0);
    $display("generator test done");
    pos_ref_generate <= 1'b0;
    ext_tc <= '{5'd12, 6'd34, 6'd56, 5'd7};
    wr(OFS_CTRL, 32'h5B0);
    repeat (2) @(posedge hclk);
    chk(32'(overlay_active), 32'h0);
    chk(32'(vertical_code_insert), 32'h0);
    video_in_present <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(32'(overlay_active), 32'h1);
    chk(32'(vertical_code_insert), 32'h1);
    chk(32'(insert_line_pair), 32'h5);
    chk(32'(overlay_tc), 32'(ext_tc));
    rd(OFS_POS, tcw(12, 34, 56, 7));
    for (int i = 0; i < 5; i++) begin
      wr(OFS_OVL, (32'(i % 4) << OVL_COL) | (32'(i) << OVL_HPOS)
                  | (32'(i) << OVL_VPOS) | 32'(i % 2));
      repeat (2) @(posedge hclk);
      chk(32'(overlay_cfg), {i[0], i[2:0], i[2:0], i[1:0]});
    end
    wr(OFS_OVL, 32'h0570);
    repeat (2) @(posedge hclk);
    chk(32'(overlay_cfg), {1'b0, 3'h4, 3'h4, 2'h0});
    wr(OFS_CTRL, 32'h80);
    repeat (2) @(posedge hclk);
    chk(32'(overlay_active), 32'h0);
    $display("overlay test done");
    ltc_out_active <= 1'b1;
    pos_ref_generate <= 1'b1;
    k = n_bytes;
    tick();
    repeat (40) @(posedge hclk);
    chk(n_qf, 4);
    chk(n_bytes - k, 8);
    ltc_out_active <= 1'b0;
    wr(OFS_CTRL, 32'h88);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 600 && n_ff <= j; i++) @(posedge hclk);
      if (j == 0) k = n_bytes;
    end
    chk(gap, 200);
    chk(n_bytes - k, 32'(FF_BYTES));
    chk(pre_ff, MTC_EOX);
    wr(OFS_CTRL, 32'h80);
    repeat (30) @(posedge hclk);
    k = n_bytes;
    repeat (500) @(posedge hclk);
    chk(n_bytes, k);
    $display("stream test done");
    stall <= 1'b1;
    wr(OFS_CTRL, 32'h88);
    repeat (1200) @(posedge hclk);
    rd(OFS_STAT, 32'h14);
    wr(OFS_CTRL, 32'h80);
    stall <= 1'b0;
    repeat (200) @(posedge hclk);
    rd(OFS_STAT, 32'h0C);
    $display("buffer test done");
    final_report();
  end
endmodule : timecode_gen_mtc_window_burn_tb
